// ===== pdd_host.sv
// host model: register requests, sync mode and pulse-count writes
`timescale 1ns/1ps
`default_nettype none
module pdd_host (
    input  wire logic         ref_clk,
    input  wire logic [7:0]   rdata_q,
    input  wire logic         rvalid_q,
    output pdd_pkg::pdd_req_s req,
    output logic [1:0]        sync_mode,
    output logic              pulse_burst_length_wr
);
    import pdd_pkg::*;
    initial req = '0;
    initial sync_mode = 2'h0;
    initial pulse_burst_length_wr = 1'b0;
    // released lines invert so stale values never look valid
    task automatic xfer(logic w, logic [12:0] a, logic [7:0] d);
        @(posedge ref_clk);
        req <= '{w, !w, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
        #1;
    endtask
    task automatic rd(logic [12:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        d = rvalid_q ? rdata_q : 8'hxx;
    endtask
    task automatic step(logic [7:0] n);
        @(posedge ref_clk);
        sync_mode <= SYNC_MODE_SPI_PULSER;
        xfer(1'b1, OFS_STEP_COUNT, n);
    endtask
    // callers keep delay powered while pulsing
    task automatic pulse();
        @(posedge ref_clk);
        sync_mode <= SYNC_MODE_SPI_PULSER;
        pulse_burst_length_wr <= 1'b1;
        @(posedge ref_clk);
        pulse_burst_length_wr <= 1'b0;
    endtask
endmodule // pdd_host
`default_nettype wire

// ===== pdd_monitor.sv
// checker: port-level properties of the power-down / delay bank
`timescale 1ns/1ps
`default_nettype none
module pdd_monitor (
    input wire logic                             ref_clk,
    input wire logic                             reset_n,
    input wire pdd_pkg::pdd_req_s                req,
    input wire logic                             rvalid_q,
    input wire logic [1:0]                       sync_mode,
    input wire logic                             pulse_burst_length_wr,
    input wire pdd_pkg::pdd_power_s              power_q,
    input wire pdd_pkg::pdd_dly_enable_s         dly_enable_q,
    input wire logic                             frame_ref_mode_allowed_q,
    input wire logic                             sync_allowed_q,
    input wire logic                             frame_ref_disable_mode_act_q,
    input wire logic                             pulser_fire_q,
    input wire logic [pdd_pkg::CLK_OUTS-1:0]     clock_step_q,
    input wire logic                             step_busy_q
);
    import pdd_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic wr_pwr;
    logic wr_step;
    assign wr_pwr  = req.wr_en && req.addr == OFS_POWER;
    assign wr_step = req.wr_en && req.addr == OFS_STEP_COUNT;
    rd_pulse_a: assert property (req.rd_en |=> rvalid_q) else $error("no read answer");
    pwr_write_a: assert property (wr_pwr |=> power_q == $past(req.wdata))
        else $error("power write lost");
    core_gate_a: assert property (frame_ref_mode_allowed_q == !power_q.frame_ref_core_power_off
        && sync_allowed_q == !power_q.frame_ref_core_power_off) else $error("core gating");
    gbl_pd_a: assert property (frame_ref_disable_mode_act_q == power_q.frame_ref_global_power_off)
        else $error("global power-off not applied");
    step_mask_a: assert property ((clock_step_q & ~dly_enable_q.dyn_delay_clock_enable) == 7'h00)
        else $error("step on disabled output");
    step_start_a: assert property (wr_step && req.wdata != 8'h00 |=> step_busy_q)
        else $error("run not started");
    pulser_a: assert property (pulse_burst_length_wr && sync_mode == 2'h3 &&
        power_q[2:0] == 3'h0 |=> pulser_fire_q) else $error("pulser silent");
    busy_cause_a: assert property ($rose(step_busy_q) |-> $past(wr_step))
        else $error("run without write");
    cover property (wr_step ##1 step_busy_q[*3]);
    cover property (pulser_fire_q);
    cover property (!frame_ref_mode_allowed_q);
endmodule // pdd_monitor
bind pdd_regs pdd_monitor mon (.*);
`default_nettype wire

// ===== pdd_pkg.sv
// package: offsets, defaults, field layouts and states of the power-down / dynamic delay bank
package pdd_pkg;
    localparam int          ADDR_W          = 13;
    localparam int          DATA_W          = 8;
    localparam int          CLK_OUTS        = 7;
    localparam int          STEP_W          = 8;

    localparam logic [12:0] OFS_POWER       = 13'h0140;
    localparam logic [12:0] OFS_DLY_ENABLE  = 13'h0141;
    localparam logic [12:0] OFS_STEP_COUNT  = 13'h0142;

    localparam logic [7:0]  RST_POWER       = 8'hE0;
    localparam logic [7:0]  RST_DLY_ENABLE  = 8'h00;
    localparam logic [7:0]  RST_STEP_COUNT  = 8'h00;

    localparam logic [1:0]  SYNC_MODE_SPI_PULSER = 2'h3;
    localparam logic [7:0]  STEP_NONE       = 8'h00;
    localparam logic [7:0]  STEP_ONE        = 8'h01;

    // minimum spacing of successive delay adjustments in ns, rounded up to ref_clk cycles
    localparam int          STEP_GAP_NS     = 40;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          STEP_GAP_CYC    = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  GAP_LOAD        = 4'(STEP_GAP_CYC - 1);
    localparam logic [3:0]  GAP_ZERO        = 4'h0;

    // bit order matches the power register, bit 7 first
    typedef struct packed {
        logic first_loop_power_off;
        logic osc_regulator_power_off;
        logic osc_core_power_off;
        logic ref_osc_input_power_off;
        logic frame_ref_global_power_off;
        logic frame_ref_core_power_off;
        logic frame_ref_delay_power_off;
        logic frame_ref_pulser_power_off;
    } pdd_power_s;

    typedef struct packed {
        logic                dyn_delay_frame_ref_enable;
        logic [CLK_OUTS-1:0] dyn_delay_clock_enable;
    } pdd_dly_enable_s;

    typedef struct packed {
        logic              wr_en;
        logic              rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pdd_req_s;

    // gray along idle -> step -> gap -> step
    typedef enum logic [1:0] {
        PDD_IDLE = 2'b00,
        PDD_STEP = 2'b01,
        PDD_GAP  = 2'b11
    } pdd_state_e;
endpackage

// ===== pdd_regs.sv
// file: power-down and dynamic digital delay register bank with step sequencer
`timescale 1ns/1ps
`default_nettype none

module pdd_regs (
    input  wire logic                              ref_clk,
    input  wire logic                              reset_n,
    input  wire pdd_pkg::pdd_req_s                 req,
    output logic [pdd_pkg::DATA_W-1:0]             rdata_q,
    output logic                                   rvalid_q,
    input  wire logic [1:0]                        sync_mode,
    input  wire logic                              pulse_burst_length_wr,
    output pdd_pkg::pdd_power_s                    power_q,
    output pdd_pkg::pdd_dly_enable_s               dly_enable_q,
    output logic [pdd_pkg::STEP_W-1:0]             dyn_delay_step_total_q,
    output logic                                   frame_ref_mode_allowed_q,
    output logic                                   sync_allowed_q,
    output logic                                   frame_ref_disable_mode_act_q,
    output logic                                   pulser_fire_q,
    output logic [pdd_pkg::CLK_OUTS-1:0]           clock_step_q,
    output logic                                   frame_ref_step_q,
    output logic                                   step_busy_q
);
    import pdd_pkg::*;

    pdd_power_s        power_d;
    pdd_dly_enable_s   dly_enable_d;
    logic [STEP_W-1:0] step_total_d;
    logic [DATA_W-1:0] rdata_d;
    logic              rvalid_d;
    logic              mode_allowed_d;
    logic              sync_allowed_d;
    logic              disable_act_d;
    logic              pulser_fire_d;

    // step sequencer
    pdd_state_e        state_q;
    pdd_state_e        state_d;
    logic [STEP_W-1:0] left_q;
    logic [STEP_W-1:0] left_d;
    logic [3:0]        gap_q;
    logic [3:0]        gap_d;
    logic [CLK_OUTS-1:0] clock_step_d;
    logic              frame_step_d;
    logic              step_now;
    logic              busy_d;
    // write strobes decoded once; step_wr is shared by the bank and the sequencer
    logic              step_wr;
    logic              power_wr;
    logic              enable_wr;

    // address match, shared by reads and writes
    function automatic logic hit(input pdd_req_s r, input logic [ADDR_W-1:0] ofs);
        hit = r.addr == ofs;
    endfunction

    // write strobe for one offset; unmapped offsets match nothing and are dropped
    function automatic logic wr_hit(input pdd_req_s r, input logic [ADDR_W-1:0] ofs);
        wr_hit = r.wr_en && hit(r, ofs);
    endfunction

    assign power_wr  = wr_hit(req, OFS_POWER);
    assign enable_wr = wr_hit(req, OFS_DLY_ENABLE);
    // only the register port can start an adjustment run
    assign step_wr   = wr_hit(req, OFS_STEP_COUNT);

    // register bank: writes land next edge, derived controls with them
    always_comb begin
        power_d        = power_q;
        dly_enable_d   = dly_enable_q;
        step_total_d   = dyn_delay_step_total_q;
        if (power_wr) begin
            power_d = pdd_power_s'(req.wdata);
        end
        if (enable_wr) begin
            dly_enable_d = pdd_dly_enable_s'(req.wdata);
        end
        if (step_wr) begin
            step_total_d = req.wdata;
        end

        // a read beside a write to the same offset sees the old value
        rvalid_d = req.rd_en;
        rdata_d  = '0;
        if (req.rd_en) begin
            if (hit(req, OFS_POWER)) begin
                rdata_d = power_q;
            end else if (hit(req, OFS_DLY_ENABLE)) begin
                rdata_d = dly_enable_q;
            end else if (hit(req, OFS_STEP_COUNT)) begin
                rdata_d = dyn_delay_step_total_q;
            end
        end

        // derived controls come from the next stored bits and update on the same edge
        mode_allowed_d = !power_d.frame_ref_core_power_off;
        sync_allowed_d = !power_d.frame_ref_core_power_off;
        disable_act_d  = power_d.frame_ref_global_power_off;

        // pulser needs core and pulser powered and the register-driven sync mode
        // delay power is left to the host, which must keep it up during sync
        pulser_fire_d  = pulse_burst_length_wr && sync_mode == SYNC_MODE_SPI_PULSER
                         && !power_q.frame_ref_core_power_off
                         && !power_q.frame_ref_pulser_power_off;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            // derived outputs reset to what the default power bits imply
            power_q                      <= pdd_power_s'(RST_POWER);
            dly_enable_q                 <= pdd_dly_enable_s'(RST_DLY_ENABLE);
            dyn_delay_step_total_q       <= RST_STEP_COUNT;
            rdata_q                      <= '0;
            rvalid_q                     <= 1'b0;
            frame_ref_mode_allowed_q     <= 1'b1;
            sync_allowed_q               <= 1'b1;
            frame_ref_disable_mode_act_q <= 1'b0;
            pulser_fire_q                <= 1'b0;
        end else begin
            power_q                      <= power_d;
            dly_enable_q                 <= dly_enable_d;
            dyn_delay_step_total_q       <= step_total_d;
            rdata_q                      <= rdata_d;
            rvalid_q                     <= rvalid_d;
            frame_ref_mode_allowed_q     <= mode_allowed_d;
            sync_allowed_q               <= sync_allowed_d;
            frame_ref_disable_mode_act_q <= disable_act_d;
            pulser_fire_q                <= pulser_fire_d;
        end
    end

    // step sequencer: a new write restarts the run with the new count
    // a zero count cancels a run in progress; sync mode is not checked here
    always_comb begin
        state_d      = state_q;
        left_d       = left_q;
        gap_d        = gap_q;
        step_now     = 1'b0;
        if (step_wr) begin
            left_d  = req.wdata;
            gap_d   = GAP_ZERO;
            state_d = (req.wdata == STEP_NONE) ? PDD_IDLE : PDD_STEP;
        end else begin
            case (state_q)
                PDD_IDLE: begin
                    state_d = PDD_IDLE;
                end
                PDD_STEP: begin
                    // the last step drops busy in the cycle its strobe leaves
                    step_now     = 1'b1;
                    left_d       = left_q - STEP_ONE;
                    gap_d        = GAP_LOAD;
                    state_d      = (left_q == STEP_ONE) ? PDD_IDLE : PDD_GAP;
                end
                PDD_GAP: begin
                    // count down from GAP_LOAD; steps land GAP_LOAD + 2 cycles apart
                    if (gap_q == GAP_ZERO) begin
                        state_d = PDD_STEP;
                    end else begin
                        gap_d = gap_q - 4'h1;
                    end
                end
                default: begin
                    state_d = PDD_IDLE;
                end
            endcase
        end
        busy_d = state_d != PDD_IDLE;
    end

    // one strobe per clock output, each gated by its own enable bit
    generate
        for (genvar g = 0; g < CLK_OUTS; g++) begin : g_clock_step
            assign clock_step_d[g] = step_now && dly_enable_q.dyn_delay_clock_enable[g];
        end
    endgenerate
    // the frame ref outputs share one enable and step together
    assign frame_step_d = step_now && dly_enable_q.dyn_delay_frame_ref_enable;

    // strobes leave flip-flops so the outputs see clean one-cycle pulses
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q          <= PDD_IDLE;
            left_q           <= STEP_NONE;
            gap_q            <= GAP_ZERO;
            clock_step_q     <= '0;
            frame_ref_step_q <= 1'b0;
            step_busy_q      <= 1'b0;
        end else begin
            state_q          <= state_d;
            left_q           <= left_d;
            gap_q            <= gap_d;
            clock_step_q     <= clock_step_d;
            frame_ref_step_q <= frame_step_d;
            step_busy_q      <= busy_d;
        end
    end
endmodule // pdd_regs

`default_nettype wire

// ===== tb_powerdown_and_dyn_delay_regs.sv
// self-checking bench for the power-down / delay bank
`timescale 1ns/1ps
`default_nettype none
module tb_powerdown_and_dyn_delay_regs;
    import pdd_pkg::*;
    typedef struct packed {logic [12:0] a; logic [7:0] d; logic [7:0] e;} pdd_row_s;
    logic            ref_clk = 1'b0;
    logic            reset_n = 1'b0;
    pdd_req_s        req;
    logic [7:0]      rdata_q, rdv, tot_q;
    logic [1:0]      sync_mode;
    logic            rvalid_q, pbl_wr, fire_q, busy_q, fr_q, allow_q, sync_q, dis_q;
    logic [6:0]      clk_q;
    pdd_power_s      power_q;
    pdd_dly_enable_s en_q;
    int              num_errors = 0, checked = 0, n_clk = 0, n_fr = 0, n_fire = 0;
    pdd_row_s rows [4] = '{'{OFS_POWER, 8'h1B, 8'h1B}, '{OFS_DLY_ENABLE, 8'hA5, 8'hA5},
        '{OFS_STEP_COUNT, 8'h00, 8'h00}, '{13'h0143, 8'hFF, 8'h00}};
    initial forever #5 ref_clk = ~ref_clk;
    pdd_host h (.ref_clk(ref_clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .req(req),
        .sync_mode(sync_mode), .pulse_burst_length_wr(pbl_wr));
    pdd_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .sync_mode(sync_mode), .pulse_burst_length_wr(pbl_wr),
        .power_q(power_q), .dly_enable_q(en_q), .dyn_delay_step_total_q(tot_q),
        .frame_ref_mode_allowed_q(allow_q), .sync_allowed_q(sync_q),
        .frame_ref_disable_mode_act_q(dis_q), .pulser_fire_q(fire_q), .clock_step_q(clk_q),
        .frame_ref_step_q(fr_q), .step_busy_q(busy_q));
    always @(posedge ref_clk) begin
        n_clk <= n_clk + $countones(clk_q);
        n_fr <= n_fr + fr_q;
        n_fire <= n_fire + fire_q;
    end
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic run(logic [7:0] en, logic [7:0] n, logic [7:0] ec, logic [7:0] ef);
        int i;
        int c0;
        int f0;
        h.xfer(1'b1, OFS_DLY_ENABLE, en);
        chk8("enable port", en, en_q);
        c0 = n_clk;
        f0 = n_fr;
        h.step(n);
        chk8("busy", {7'h0, n != 8'h00}, {7'h0, busy_q});
        chk8("step total", n, tot_q);
        for (i = 0; i < 40 && busy_q !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 40) begin
            chk8("run end", 8'h00, 8'hFF);
            end_sim();
        end
        repeat (3) @(posedge ref_clk);
        #1;
        chk8("clock steps", ec, 8'(n_clk - c0));
        chk8("frame steps", ef, 8'(n_fr - f0));
        $display("test run %h done", n);
    endtask
    initial begin
        int c0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        h.rd(OFS_POWER, rdv);
        chk8("power reset", RST_POWER, rdv);
        h.rd(OFS_DLY_ENABLE, rdv);
        chk8("enable reset", RST_DLY_ENABLE, rdv);
        h.rd(OFS_STEP_COUNT, rdv);
        chk8("step reset", RST_STEP_COUNT, rdv);
        $display("test reset done");
        foreach (rows[i]) begin
            h.xfer(1'b1, rows[i].a, rows[i].d);
            h.rd(rows[i].a, rdv);
            chk8("readback", rows[i].e, rdv);
        end
        $display("test table done");
        h.xfer(1'b1, OFS_POWER, 8'h0C);
        chk8("derived", 8'h01, {5'h0, allow_q, sync_q, dis_q});
        chk8("power port", 8'h0C, power_q);
        h.pulse();
        h.xfer(1'b1, OFS_POWER, 8'h00);
        chk8("core on", 8'h03, {6'h0, allow_q, sync_q});
        h.pulse();
        repeat (2) @(posedge ref_clk);
        #1;
        chk8("fires", 8'h01, 8'(n_fire));
        $display("test pulser done");
        run(8'h01, 8'h02, 8'h02, 8'h00);
        run(8'h80, 8'h01, 8'h00, 8'h01);
        run(8'h7F, 8'h00, 8'h00, 8'h00);
        run(8'hFF, 8'h03, 8'h15, 8'h03);
        h.xfer(1'b1, OFS_DLY_ENABLE, 8'h01);
        c0 = n_clk;
        h.step(8'h05);
        h.step(8'h01);
        repeat (12) @(posedge ref_clk);
        #1;
        chk8("restart steps", 8'h02, 8'(n_clk - c0));
        chk8("restart idle", 8'h00, {7'h0, busy_q});
        $display("test restart done");
        end_sim();
    end
endmodule // tb_powerdown_and_dyn_delay_regs
`default_nettype wire
